// File: hw/hsq_homing.sv
// Function
// - Method 21 searches negative fast, turns positive slow on the home rise and stops on the fall, or starts positive slow when active.
// - Method 22 goes negative slow to the home rise when inactive, or positive fast to the fall then negative slow to the rise.
// - Method 23 searches positive fast, turns negative slow on the home rise and stops on the fall, or starts negative slow.
// - In methods 23 to 26 a limit hit during the positive fast search turns the search negative fast, 23 and 24 then slow on rise.
// - Method 24 runs like 23 but on the fall turns positive slow and stops on the next rise, active start going negative slow first.
// - Method 25 searches positive fast, runs positive slow from the rise, turns negative slow on the fall and stops on the rise.
// - Method 25 active start runs positive slow, negative slow from the fall, stops on rise; method 26 stops at the fall.
// - Method 27 searches negative fast, turns positive fast at the limit, runs positive slow from the rise and stops on the fall.
// - Method 28 runs like 27 but on the fall turns negative slow and stops on the next rise.
// - Except in method 22, a home switch already active at start skips the fast search and starts slow in the method's direction.
`timescale 1ns/100ps
`default_nettype none
`include "hsq_regs.svh"

module hsq_homing
    import hsq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Homing request
    input wire logic start,
    input wire logic [`HSQ_METHOD_W-1:0] method,
    // Switch inputs
    input wire logic home_switch_input,
    input wire logic limit_pos,
    input wire logic limit_neg,
    // Motor commands
    output logic motor_run,
    output logic motor_dir,
    output logic motor_fast,
    // Status
    output logic busy,
    output logic done,
    output logic error
);

    hsq_core_s q;
    hsq_core_s d;
    hsq_plan_s plan;
    logic [`HSQ_SYNC_W-1:0] sw_lvl;
    logic [`HSQ_SYNC_W-1:0] sw_rise;
    logic [`HSQ_SYNC_W-1:0] sw_fall;
    logic home_lvl;
    logic edge_hit;
    logic lim_hit;
    logic can_reverse;

    // ----------------------------------------------------------------
    // Switch conditioning
    // ----------------------------------------------------------------
    hsq_sync #(
        .W(`HSQ_SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din({limit_neg, limit_pos, home_switch_input}),
        .lvl(sw_lvl),
        .rise(sw_rise),
        .fall(sw_fall)
    );

    assign home_lvl = sw_lvl[`HSQ_IN_HOME];

    // ----------------------------------------------------------------
    // Method decode
    // ----------------------------------------------------------------
    // Methods differ in each phase's direction, the fast phase and the second slow phase; the edge
    // to wait for simply alternates, starting from the opposite of the level
    function automatic hsq_plan_s decode(input logic [`HSQ_METHOD_W-1:0] m, input logic act);
        hsq_plan_s p;
        p = '0;
        p.valid = 1'b1;
        case (m)
            `HSQ_METH_21: begin
                p.has_high = ~act;
                p.first_dir = act ? `HSQ_DIR_POS : `HSQ_DIR_NEG;
                p.low1_dir = `HSQ_DIR_POS;
            end
            `HSQ_METH_22: begin
                p.has_high = act;
                p.first_dir = act ? `HSQ_DIR_POS : `HSQ_DIR_NEG;
                p.low1_dir = `HSQ_DIR_NEG;
            end
            `HSQ_METH_23, `HSQ_METH_24: begin
                p.has_high = ~act;
                p.first_dir = act ? `HSQ_DIR_NEG : `HSQ_DIR_POS;
                p.low1_dir = `HSQ_DIR_NEG;
                p.two_low = (m == `HSQ_METH_24);
            end
            `HSQ_METH_25, `HSQ_METH_26: begin
                p.has_high = ~act;
                p.first_dir = `HSQ_DIR_POS;
                p.low1_dir = `HSQ_DIR_POS;
                p.two_low = (m == `HSQ_METH_25);
            end
            `HSQ_METH_27, `HSQ_METH_28: begin
                p.has_high = ~act;
                p.first_dir = act ? `HSQ_DIR_POS : `HSQ_DIR_NEG;
                p.low1_dir = `HSQ_DIR_POS;
                p.two_low = (m == `HSQ_METH_28);
            end
            default: begin
                p.valid = 1'b0;
            end
        endcase
        return p;
    endfunction : decode

    assign plan = decode(method, home_lvl);
    assign edge_hit = q.want_rise ? sw_rise[`HSQ_IN_HOME] : sw_fall[`HSQ_IN_HOME];
    assign lim_hit = q.dir ? sw_lvl[`HSQ_IN_LPOS] : sw_lvl[`HSQ_IN_LNEG];
    // Limit reversal is defined for methods 23 to 28 only, and once per search
    assign can_reverse = (q.meth >= `HSQ_METH_23) && (q.meth <= `HSQ_METH_28) && !q.reversed;

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.err = 1'b0;
        case (q.st)
            HSQ_IDLE: begin
                if (start) begin
                    if (!plan.valid) begin
                        d.err = 1'b1;
                    end else begin
                        d.meth = method;
                        d.want_rise = ~home_lvl;
                        d.low1_dir = plan.low1_dir;
                        d.two_low = plan.two_low;
                        d.reversed = 1'b0;
                        d.run = 1'b1;
                        d.dir = plan.first_dir;
                        d.fast = plan.has_high;
                        d.st = plan.has_high ? HSQ_HIGH : HSQ_LOW1;
                    end
                end
            end
            HSQ_HIGH: begin
                if (edge_hit) begin
                    d.st = HSQ_LOW1;
                    d.fast = 1'b0;
                    d.dir = q.low1_dir;
                    d.want_rise = ~q.want_rise;
                end else if (lim_hit && can_reverse) begin
                    d.dir = ~q.dir;
                    d.reversed = 1'b1;
                end else if (lim_hit) begin
                    d = '0;
                    d.err = 1'b1;
                end
            end
            HSQ_LOW1, HSQ_LOW2: begin
                if (edge_hit && q.st == HSQ_LOW1 && q.two_low) begin
                    d.st = HSQ_LOW2;
                    d.dir = ~q.dir;
                    d.want_rise = ~q.want_rise;
                end else if (edge_hit) begin
                    d.st = HSQ_IDLE;
                    d.run = 1'b0;
                    d.done = 1'b1;
                end else if (lim_hit) begin
                    // A limit in a slow phase means the switch was missed
                    d = '0;
                    d.err = 1'b1;
                end
            end
            default: begin
                d = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs straight from flops except busy, decoded from the state
    // ----------------------------------------------------------------
    assign motor_run = q.run;
    assign motor_dir = q.dir;
    assign motor_fast = q.fast;
    assign busy = (q.st != HSQ_IDLE);
    assign done = q.done;
    assign error = q.err;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic go;
    assign go = start && (q.st == HSQ_IDLE);

    property p_bad_method;
        @(posedge sys_clk) disable iff (!rst_n)
        go && !plan.valid |=> error && !motor_run ##1 !error && !motor_run;
    endproperty
    a_bad_method: assert property (p_bad_method) else $error("bad method moved the motor");

    property p_active_slow;
        @(posedge sys_clk) disable iff (!rst_n)
        go && plan.valid && home_lvl && method != `HSQ_METH_22 |=> motor_run && !motor_fast && busy;
    endproperty
    a_active_slow: assert property (p_active_slow) else $error("active start ran fast");

    property p_m21_search;
        @(posedge sys_clk) disable iff (!rst_n)
        go && method == `HSQ_METH_21 && !home_lvl |=> motor_fast && motor_dir == `HSQ_DIR_NEG;
    endproperty
    a_m21_search: assert property (p_m21_search) else $error("method 21 search wrong");

    property p_m22_inactive;
        @(posedge sys_clk) disable iff (!rst_n)
        go && method == `HSQ_METH_22 && !home_lvl |=> !motor_fast && motor_dir == `HSQ_DIR_NEG;
    endproperty
    a_m22_inactive: assert property (p_m22_inactive) else $error("method 22 start wrong");

    property p_m23_search;
        @(posedge sys_clk) disable iff (!rst_n)
        go && method == `HSQ_METH_23 && !home_lvl |=> motor_fast && motor_dir == `HSQ_DIR_POS;
    endproperty
    a_m23_search: assert property (p_m23_search) else $error("method 23 search wrong");

    property p_limit_rev;
        @(posedge sys_clk) disable iff (!rst_n)
        q.st == HSQ_HIGH && !edge_hit && lim_hit && can_reverse |=> motor_fast && motor_dir != $past(motor_dir);
    endproperty
    a_limit_rev: assert property (p_limit_rev) else $error("no reversal at limit");

    property p_m24_active;
        @(posedge sys_clk) disable iff (!rst_n)
        go && method == `HSQ_METH_24 && home_lvl |=> !motor_fast && motor_dir == `HSQ_DIR_NEG;
    endproperty
    a_m24_active: assert property (p_m24_active) else $error("method 24 active start wrong");

    property p_m25_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        q.st == HSQ_HIGH && q.meth == `HSQ_METH_25 && edge_hit |=> !motor_fast && motor_dir == `HSQ_DIR_POS;
    endproperty
    a_m25_rise: assert property (p_m25_rise) else $error("method 25 slow phase wrong");

    property p_m26_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        q.st == HSQ_LOW1 && q.meth == `HSQ_METH_26 && edge_hit |=> done && !motor_run && !busy;
    endproperty
    a_m26_stop: assert property (p_m26_stop) else $error("method 26 did not stop");

    property p_m27_search;
        @(posedge sys_clk) disable iff (!rst_n)
        go && method == `HSQ_METH_27 && !home_lvl |=> motor_fast && motor_dir == `HSQ_DIR_NEG;
    endproperty
    a_m27_search: assert property (p_m27_search) else $error("method 27 search wrong");

    property p_m28_turn;
        @(posedge sys_clk) disable iff (!rst_n)
        q.st == HSQ_LOW1 && q.meth == `HSQ_METH_28 && edge_hit |=> motor_run && motor_dir == `HSQ_DIR_NEG;
    endproperty
    a_m28_turn: assert property (p_m28_turn) else $error("method 28 turn wrong");

    c_done: cover property (@(posedge sys_clk) disable iff (!rst_n) done);
    c_reversal: cover property (@(posedge sys_clk) disable iff (!rst_n) q.st == HSQ_HIGH && q.reversed);
    c_two_low: cover property (@(posedge sys_clk) disable iff (!rst_n) q.st == HSQ_LOW2 ##1 done);

endmodule : hsq_homing

`default_nettype wire

// File: hw/hsq_regs.svh
`ifndef HSQ_REGS_SVH
`define HSQ_REGS_SVH

// ----------------------------------------------------------------
// Homing method codes and encodings
// ----------------------------------------------------------------
`define HSQ_METHOD_W 8
`define HSQ_METH_21 8'h15
`define HSQ_METH_22 8'h16
`define HSQ_METH_23 8'h17
`define HSQ_METH_24 8'h18
`define HSQ_METH_25 8'h19
`define HSQ_METH_26 8'h1a
`define HSQ_METH_27 8'h1b
`define HSQ_METH_28 8'h1c
`define HSQ_DIR_POS 1'b1
`define HSQ_DIR_NEG 1'b0
`define HSQ_SYNC_W 3
`define HSQ_IN_HOME 0
`define HSQ_IN_LPOS 1
`define HSQ_IN_LNEG 2

`endif

// File: hw/hsq_pkg.sv
`include "hsq_regs.svh"

package hsq_pkg;

    // ----------------------------------------------------------------
    // Sequencer phases, Gray along idle, high, low1, low2
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HSQ_IDLE = 2'b00,
        HSQ_HIGH = 2'b01,
        HSQ_LOW1 = 2'b11,
        HSQ_LOW2 = 2'b10
    } hsq_state_e;

    // Decoded plan of one method for one start level
    typedef struct packed {
        logic valid;
        logic has_high;
        logic first_dir;
        logic low1_dir;
        logic two_low;
    } hsq_plan_s;

    // Whole state of the sequencer core
    typedef struct packed {
        hsq_state_e st;
        logic [`HSQ_METHOD_W-1:0] meth;
        logic want_rise;
        logic low1_dir;
        logic two_low;
        logic reversed;
        logic run;
        logic dir;
        logic fast;
        logic done;
        logic err;
    } hsq_core_s;

endpackage : hsq_pkg

// File: hw/hsq_sync.sv
`timescale 1ns/100ps
`default_nettype none

module hsq_sync
    import hsq_pkg::*;
#(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Raw switch levels
    input wire logic [W-1:0] din,
    // Synchronised level and one-cycle edges
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } hsq_sync_s;

    hsq_sync_s q;
    hsq_sync_s d;

    // ----------------------------------------------------------------
    // Two-stage synchroniser plus one history stage for edges
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    // Synchronous reset; switches read as released until sampled
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Edges look only at stages two and three, never at stage one
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign lvl[i] = q.s2[i];
        assign rise[i] = q.s2[i] & ~q.s3[i];
        assign fall[i] = ~q.s2[i] & q.s3[i];
    end

endmodule : hsq_sync

`default_nettype wire

// File: test/hsq_motor_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Motor and switch model
// ----------------------------------------------------------------
module hsq_motor_model #(
    parameter int HOME_LO = 100,
    parameter int HOME_HI = 199,
    parameter int LIM = 1000
) (
    // Clock and position preset
    input wire logic sys_clk,
    input wire logic load,
    input wire logic signed [15:0] load_pos,
    // Motor commands
    input wire logic motor_run,
    input wire logic motor_dir,
    input wire logic motor_fast,
    // Switch levels
    output logic home_switch_input,
    output logic limit_pos,
    output logic limit_neg
);
    int pos = 0;

    // Axis moves four units a cycle fast and one slow, so fast overshoot stays inside the home window
    always @(posedge sys_clk) begin
        if (load) begin
            pos <= int'(load_pos);
        end else if (motor_run) begin
            pos <= pos + (motor_dir ? (motor_fast ? 4 : 1) : (motor_fast ? -4 : -1));
        end
    end

    // Switches are clean levels decoded from position
    assign home_switch_input = (pos >= HOME_LO) && (pos <= HOME_HI);
    assign limit_pos = pos >= LIM;
    assign limit_neg = pos <= -LIM;
endmodule : hsq_motor_model

`default_nettype wire

// File: test/home_switch_homing_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsq_regs.svh"

module home_switch_homing_sequencer_tb
    import hsq_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] method = 8'h00;
    logic load = 1'b0;
    logic signed [15:0] load_pos = 16'sh0000;
    logic home_switch_input, limit_pos, limit_neg;
    logic motor_run, motor_dir, motor_fast, busy, done, error;
    logic [15:0] got;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    hsq_homing dut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .method(method),
        .home_switch_input(home_switch_input), .limit_pos(limit_pos), .limit_neg(limit_neg),
        .motor_run(motor_run), .motor_dir(motor_dir), .motor_fast(motor_fast),
        .busy(busy), .done(done), .error(error));

    hsq_motor_model motor (.sys_clk(sys_clk), .load(load), .load_pos(load_pos),
        .motor_run(motor_run), .motor_dir(motor_dir), .motor_fast(motor_fast),
        .home_switch_input(home_switch_input), .limit_pos(limit_pos), .limit_neg(limit_neg));

    always #4 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Run limit and closing report
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("Mismatches %0d in %0d checks", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Outcome word: done, error, home level, busy and motor run at end, phase count, phase list {dir,fast}
    function automatic logic [15:0] pack(input logic [7:0] s, input logic [2:0] n, input logic home,
                                         input logic dn);
        return {dn, ~dn, home, 1'b0, 1'b0, n, s};
    endfunction : pack

    // Presets the axis, starts one method and logs every phase until done or error
    task automatic run_case(input logic [7:0] meth, input int pos0, input logic poke);
        int i;
        logic [1:0] last;
        logic [7:0] seq;
        logic [2:0] n;
        logic dn, er, hm, bz;
        seq = 8'h00;
        n = 3'h0;
        dn = 1'b0;
        er = 1'b0;
        hm = 1'b0;
        bz = 1'b0;
        last = 2'b00;
        load = 1'b1;
        load_pos = pos0[15:0];
        @(negedge sys_clk);
        load = 1'b0;
        // Synchronisers need a few cycles to see the preset level
        repeat (5) @(negedge sys_clk);
        start = 1'b1;
        method = meth;
        @(negedge sys_clk);
        start = 1'b0;
        // A taken request shows busy at once; a refused code never does
        check("busy at start", {15'h0000, busy}, {15'h0000, (meth >= `HSQ_METH_21) && (meth <= `HSQ_METH_28)});
        for (i = 0; i < 3000; i++) begin
            // A request while busy must be dropped without any indication
            start = poke && (i == 20);
            if (poke && i == 20) method = 8'h00;
            if (motor_run === 1'b1 && (n == 3'h0 || {motor_dir, motor_fast} !== last)) begin
                seq = {seq[5:0], motor_dir, motor_fast};
                last = {motor_dir, motor_fast};
                n++;
            end
            if (done === 1'b1 || error === 1'b1) begin
                dn = done;
                er = error;
                hm = home_switch_input;
                bz = busy;
                break;
            end
            @(negedge sys_clk);
        end
        // Motor must stand still once the sequence has ended
        got = {dn, er, hm, bz, motor_run, n, seq};
        repeat (2) @(negedge sys_clk);
    endtask : run_case

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_search_neg();
        run_case(`HSQ_METH_21, 500, 1'b0);
        check("m21 inactive", got, pack(8'h06, 3'h2, 1'b0, 1'b1));
        run_case(`HSQ_METH_21, 150, 1'b0);
        check("m21 active", got, pack(8'h02, 3'h1, 1'b0, 1'b1));
        run_case(`HSQ_METH_22, 500, 1'b0);
        check("m22 inactive", got, pack(8'h00, 3'h1, 1'b1, 1'b1));
        run_case(`HSQ_METH_22, 150, 1'b0);
        check("m22 active", got, pack(8'h0c, 3'h2, 1'b1, 1'b1));
    endtask : t_search_neg

    task automatic t_search_pos();
        run_case(`HSQ_METH_23, 0, 1'b0);
        check("m23 inactive", got, pack(8'h0c, 3'h2, 1'b0, 1'b1));
        run_case(`HSQ_METH_23, 150, 1'b0);
        check("m23 active", got, pack(8'h00, 3'h1, 1'b0, 1'b1));
        run_case(`HSQ_METH_24, 150, 1'b0);
        check("m24 active", got, pack(8'h02, 3'h2, 1'b1, 1'b1));
        run_case(`HSQ_METH_25, 150, 1'b0);
        check("m25 active", got, pack(8'h08, 3'h2, 1'b1, 1'b1));
        run_case(`HSQ_METH_26, 150, 1'b0);
        check("m26 active", got, pack(8'h02, 3'h1, 1'b0, 1'b1));
        run_case(`HSQ_METH_27, 150, 1'b0);
        check("m27 active", got, pack(8'h02, 3'h1, 1'b0, 1'b1));
    endtask : t_search_pos

    task automatic t_limit_reverse();
        run_case(`HSQ_METH_23, 500, 1'b0);
        check("m23 limit", got, pack(8'h34, 3'h3, 1'b0, 1'b1));
        run_case(`HSQ_METH_24, 500, 1'b0);
        check("m24 limit", got, pack(8'hd2, 3'h4, 1'b1, 1'b1));
        run_case(`HSQ_METH_25, 500, 1'b0);
        check("m25 limit", got, pack(8'hd8, 3'h4, 1'b1, 1'b1));
        run_case(`HSQ_METH_26, 500, 1'b0);
        check("m26 limit", got, pack(8'h36, 3'h3, 1'b0, 1'b1));
        run_case(`HSQ_METH_27, 0, 1'b0);
        check("m27 limit", got, pack(8'h1e, 3'h3, 1'b0, 1'b1));
    endtask : t_limit_reverse

    task automatic t_refused();
        run_case(`HSQ_METH_28, 500, 1'b1);
        check("m28 inactive", got, pack(8'h18, 3'h3, 1'b1, 1'b1));
        run_case(`HSQ_METH_28, 150, 1'b0);
        check("m28 active", got, pack(8'h08, 3'h2, 1'b1, 1'b1));
        run_case(8'h14, 500, 1'b0);
        check("code below set", got, pack(8'h00, 3'h0, 1'b0, 1'b0));
        run_case(8'h1d, 500, 1'b0);
        check("code above set", got, pack(8'h00, 3'h0, 1'b0, 1'b0));
        run_case(`HSQ_METH_21, 0, 1'b0);
        check("m21 limit", got, pack(8'h01, 3'h1, 1'b0, 1'b0));
    endtask : t_refused

    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_search_neg();
        t_search_pos();
        t_limit_reverse();
        t_refused();
        results();
    end
endmodule : home_switch_homing_sequencer_tb

`default_nettype wire
